// ===== hw/calib_status_int_enable.sv
// How it works
// - Auto adjust sets self-clearing offset flag
// - Calibration completion sets done flag
// - Writing one clears done flag
// - Done interrupts only with calibration enable
// - Enable bit 6 gates saturation source
// - Enable bit 5 gates proximity source
// - Enable bit 3 gates calibration source
// - Enable bit 2 gates offset adjust source
// - Zero result decrements offset, sets flag
`timescale 1ns/1ps
module calib_status_int_enable
   import calib_int_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic calib_done_i,
   input wire logic auto_offset_en_i,
   input wire logic meas_valid_i,
   input wire logic [9:0] meas_data_i,
   input wire logic prox_event_i,
   input wire logic sat_event_i,
   output logic [7:0] reg_rdata_o,
   output logic [7:0] offset_o,
   output logic int_b_o
);
   logic calib_done_q, calib_done_d;
   logic offs_chg_q, offs_chg_d;
   logic [7:0] enab_q, enab_d;
   logic [7:0] offset_q, offset_d;
   logic [7:0] rdata_q, rdata_d;
   logic int_b_q, int_b_d;
   logic zero_hit;
   logic rd_status;

   always_comb begin
      zero_hit = auto_offset_en_i && meas_valid_i && (meas_data_i == 10'h000);
      rd_status = reg_rd_i && (reg_addr_i == CALIB_STATUS_ADDR);
      calib_done_d = calib_done_q;
      if (reg_wr_i && reg_addr_i == CALIB_STATUS_ADDR && reg_wdata_i[CALIB_DONE_BIT]) begin
         calib_done_d = 1'b0;
      end
      // Set wins so a finished run is never lost
      // set beats clear
      if (calib_done_i) begin
         calib_done_d = 1'b1;
      end
      // Read clears; a zero hit in that cycle still wins
      // self-clearing on read
      offs_chg_d = offs_chg_q;
      if (rd_status) begin
         offs_chg_d = 1'b0;
      end
      // Offset wraps below zero; engine keeps it in range
      // zero result adjusts offset
      offset_d = offset_q;
      if (zero_hit) begin
         offs_chg_d = 1'b1;
         offset_d = offset_q - 8'h01;
      end
      enab_d = enab_q;
      if (reg_wr_i && reg_addr_i == INT_ENABLES_ADDR) begin
         enab_d = reg_wdata_i & INT_ENABLES_MASK;
      end
      rdata_d = rdata_q;
      if (reg_rd_i) begin
         unique case (reg_addr_i)
            CALIB_STATUS_ADDR: begin
               rdata_d = 8'h00;
               rdata_d[CALIB_DONE_BIT] = calib_done_q;
               rdata_d[OFFSET_CHANGED_BIT] = offs_chg_q;
            end
            INT_ENABLES_ADDR: rdata_d = enab_q;
            default: rdata_d = 8'h00;
         endcase
      end
      // Registered pin costs a cycle but never glitches
      // enabled sources drive pin
      int_b_d = !((calib_done_q && enab_q[CALIB_EN_BIT])
                || (offs_chg_q && enab_q[ZERO_EN_BIT])
                || (prox_event_i && enab_q[PROX_EN_BIT])
                || (sat_event_i && enab_q[SAT_EN_BIT]));
   end

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         calib_done_q <= CALIB_STATUS_RESET[CALIB_DONE_BIT];
         offs_chg_q <= CALIB_STATUS_RESET[OFFSET_CHANGED_BIT];
         enab_q <= INT_ENABLES_RESET;
         offset_q <= OFFSET_RESET;
         rdata_q <= 8'h00;
         int_b_q <= 1'b1;
      end else begin
         calib_done_q <= calib_done_d;
         offs_chg_q <= offs_chg_d;
         enab_q <= enab_d;
         offset_q <= offset_d;
         rdata_q <= rdata_d;
         int_b_q <= int_b_d;
      end
   end

   assign reg_rdata_o = rdata_q;
   assign offset_o = offset_q;
   assign int_b_o = int_b_q;

   property p_done_set;
      @(posedge clk_sys_i) disable iff (!rst_b_i) calib_done_i |=> calib_done_q;
   endproperty
   a_done_set: assert property (p_done_set) else $error("done flag not set");
   property p_done_clr;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
         reg_wr_i && reg_addr_i == CALIB_STATUS_ADDR && reg_wdata_i[0] && !calib_done_i
         |=> !calib_done_q;
   endproperty
   a_done_clr: assert property (p_done_clr) else $error("done flag not cleared");
   property p_done_keep;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
         calib_done_q && !(reg_wr_i && reg_addr_i == CALIB_STATUS_ADDR && reg_wdata_i[0])
         |=> calib_done_q;
   endproperty
   a_done_keep: assert property (p_done_keep) else $error("done flag lost");
   property p_done_int;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
         calib_done_q && enab_q[CALIB_EN_BIT] |=> !int_b_o;
   endproperty
   a_done_int: assert property (p_done_int) else $error("no calibration interrupt");
   property p_quiet;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
         enab_q == 8'h00 |=> int_b_o;
   endproperty
   a_quiet: assert property (p_quiet) else $error("interrupt while disabled");
   property p_enab_wr;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
         reg_wr_i && reg_addr_i == INT_ENABLES_ADDR
         |=> enab_q == ($past(reg_wdata_i) & 8'h6c);
   endproperty
   a_enab_wr: assert property (p_enab_wr) else $error("enable write lost");
   property p_sat;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
         sat_event_i && enab_q[SAT_EN_BIT] |=> !int_b_o;
   endproperty
   a_sat: assert property (p_sat) else $error("saturation not signalled");
   property p_prox;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
         prox_event_i && enab_q[PROX_EN_BIT] |=> !int_b_o;
   endproperty
   a_prox: assert property (p_prox) else $error("proximity not signalled");
   property p_zero;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
         zero_hit |=> offs_chg_q && offset_o == $past(offset_o) - 8'h01;
   endproperty
   a_zero: assert property (p_zero) else $error("offset not adjusted");
   property p_offs_int;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
         offs_chg_q && enab_q[ZERO_EN_BIT] |=> !int_b_o;
   endproperty
   a_offs_int: assert property (p_offs_int) else $error("offset irq missing");
   property p_selfclr;
      @(posedge clk_sys_i) disable iff (!rst_b_i) rd_status && !zero_hit |=> !offs_chg_q;
   endproperty
   a_selfclr: assert property (p_selfclr) else $error("offset flag stuck");
   property p_cien;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
         reg_wr_i && reg_addr_i == INT_ENABLES_ADDR && reg_wdata_i[3] |=> enab_q[CALIB_EN_BIT];
   endproperty
   a_cien: assert property (p_cien) else $error("calibration enable lost");
   c_done: cover property (@(posedge clk_sys_i) calib_done_q && !int_b_o);
   c_zero: cover property (@(posedge clk_sys_i) zero_hit);
   property p_done_masked;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
         calib_done_q && !enab_q[CALIB_EN_BIT] && !offs_chg_q && !prox_event_i && !sat_event_i
         |=> int_b_o;
   endproperty
   a_done_masked: assert property (p_done_masked) else $error("done irq not masked");
   property p_offs_masked;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
         offs_chg_q && !enab_q[ZERO_EN_BIT] && !calib_done_q && !prox_event_i && !sat_event_i
         |=> int_b_o;
   endproperty
   a_offs_masked: assert property (p_offs_masked) else $error("offset irq not masked");
   property p_prox_masked;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
         prox_event_i && !enab_q[PROX_EN_BIT] && !calib_done_q && !offs_chg_q && !sat_event_i
         |=> int_b_o;
   endproperty
   a_prox_masked: assert property (p_prox_masked) else $error("prox irq not masked");
   property p_sat_masked;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
         sat_event_i && !enab_q[SAT_EN_BIT] && !calib_done_q && !offs_chg_q && !prox_event_i
         |=> int_b_o;
   endproperty
   a_sat_masked: assert property (p_sat_masked) else $error("sat irq not masked");
   property p_enab_rsvd;
      @(posedge clk_sys_i) disable iff (!rst_b_i) (enab_q & ~INT_ENABLES_MASK) == 8'h00;
   endproperty
   a_enab_rsvd: assert property (p_enab_rsvd) else $error("reserved enable set");
   property p_offs_keep;
      @(posedge clk_sys_i) disable iff (!rst_b_i) offs_chg_q && !rd_status |=> offs_chg_q;
   endproperty
   a_offs_keep: assert property (p_offs_keep) else $error("offset flag lost");
   property p_offs_hold;
      @(posedge clk_sys_i) disable iff (!rst_b_i) !zero_hit |=> $stable(offset_o);
   endproperty
   a_offs_hold: assert property (p_offs_hold) else $error("offset moved");
   property p_rd_status;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
         rd_status |=> reg_rdata_o == {5'h00, $past(offs_chg_q), 1'b0, $past(calib_done_q)};
   endproperty
   a_rd_status: assert property (p_rd_status) else $error("status read wrong");
   property p_rd_enab;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
         reg_rd_i && reg_addr_i == INT_ENABLES_ADDR |=> reg_rdata_o == $past(enab_q);
   endproperty
   a_rd_enab: assert property (p_rd_enab) else $error("enable read wrong");
   c_clear: cover property (@(posedge clk_sys_i) calib_done_q ##1 !calib_done_q);
   c_offs_irq: cover property (@(posedge clk_sys_i) offs_chg_q && !int_b_o);
   c_sat_irq: cover property (@(posedge clk_sys_i) sat_event_i && enab_q[SAT_EN_BIT] ##1 !int_b_o);
endmodule

// ===== hw/calib_int_pkg.sv
package calib_int_pkg;
   localparam logic [7:0] CALIB_STATUS_ADDR = 8'hdc;
   localparam logic [7:0] INT_ENABLES_ADDR = 8'hdd;
   localparam logic [7:0] CALIB_STATUS_RESET = 8'h00;
   localparam logic [7:0] INT_ENABLES_RESET = 8'h00;
   localparam int CALIB_DONE_BIT = 0;
   localparam int OFFSET_CHANGED_BIT = 2;
   localparam int ZERO_EN_BIT = 2;
   localparam int CALIB_EN_BIT = 3;
   localparam int PROX_EN_BIT = 5;
   localparam int SAT_EN_BIT = 6;
   localparam logic [7:0] INT_ENABLES_MASK = 8'h6c;
   localparam logic [7:0] OFFSET_RESET = 8'h00;
endpackage

// ===== bench/host_model.sv
`timescale 1ns/1ps
module host_model (
   input wire logic clk_sys_i,
   output logic reg_wr_o = 1'b0,
   output logic reg_rd_o = 1'b0,
   output logic [7:0] reg_addr_o = 8'h00,
   output logic [7:0] reg_wdata_o = 8'h00
);
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      #1;
      reg_wr_o = wr;
      reg_rd_o = ~wr;
      reg_addr_o = a;
      reg_wdata_o = d;
      @(posedge clk_sys_i);
      #1;
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      // Released lines show junk, not stale data
      reg_addr_o = ~a;
      reg_wdata_o = ~d;
   endtask
endmodule

// ===== bench/calib_status_int_enable_tb_top.sv
`timescale 1ns/1ps
module calib_status_int_enable_tb_top;
   import calib_int_pkg::*;
   logic clk_sys_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic wr, rd, done = 1'b0, auto = 1'b0, mv = 1'b0, prox = 1'b0, sat = 1'b0, int_b;
   logic [7:0] addr, wdata, rdata, offset;
   logic [9:0] mdata = 10'h3ff;
   int n_fail = 0;
   int checks = 0;
   host_model host (.clk_sys_i(clk_sys_i), .reg_wr_o(wr), .reg_rd_o(rd),
      .reg_addr_o(addr), .reg_wdata_o(wdata));
   calib_status_int_enable dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata), .calib_done_i(done),
      .auto_offset_en_i(auto), .meas_valid_i(mv), .meas_data_i(mdata),
      .prox_event_i(prox), .sat_event_i(sat), .reg_rdata_o(rdata),
      .offset_o(offset), .int_b_o(int_b));
   initial begin
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      host.xfer(1'b0, a, 8'h00);
      cmp("rdata", exp, rdata);
   endtask
   // Two edges: flag update, then registered interrupt
   task automatic int_chk(input logic exp);
      repeat (2) @(posedge clk_sys_i);
      #1;
      cmp("int_b", {7'h00, exp}, {7'h00, int_b});
   endtask
   task automatic pulse(input logic meas);
      @(posedge clk_sys_i);
      #1;
      if (meas) mv = 1'b1;
      else done = 1'b1;
      @(posedge clk_sys_i);
      #1;
      mv = 1'b0;
      done = 1'b0;
   endtask
   task automatic t_regs();
      rd_chk(CALIB_STATUS_ADDR, 8'h00);
      int_chk(1'b1);
      host.xfer(1'b1, INT_ENABLES_ADDR, 8'hff);
      rd_chk(INT_ENABLES_ADDR, 8'h6c);
      rd_chk(8'h10, 8'h00);
      host.xfer(1'b1, INT_ENABLES_ADDR, 8'h00);
      rd_chk(INT_ENABLES_ADDR, 8'h00);
   endtask
   task automatic t_calib();
      pulse(1'b0);
      rd_chk(CALIB_STATUS_ADDR, 8'h01);
      int_chk(1'b1);
      host.xfer(1'b1, INT_ENABLES_ADDR, 8'h08);
      int_chk(1'b0);
      host.xfer(1'b1, CALIB_STATUS_ADDR, 8'h00);
      rd_chk(CALIB_STATUS_ADDR, 8'h01);
      host.xfer(1'b1, CALIB_STATUS_ADDR, 8'h01);
      rd_chk(CALIB_STATUS_ADDR, 8'h00);
      int_chk(1'b1);
   endtask
   task automatic t_offset();
      auto = 1'b1;
      pulse(1'b1);
      cmp("offset", 8'h00, offset);
      mdata = 10'h000;
      pulse(1'b1);
      cmp("offset", 8'hff, offset);
      host.xfer(1'b1, INT_ENABLES_ADDR, 8'h04);
      int_chk(1'b0);
      rd_chk(CALIB_STATUS_ADDR, 8'h04);
      rd_chk(CALIB_STATUS_ADDR, 8'h00);
      int_chk(1'b1);
   endtask
   task automatic t_events();
      prox = 1'b1;
      int_chk(1'b1);
      host.xfer(1'b1, INT_ENABLES_ADDR, 8'h20);
      int_chk(1'b0);
      prox = 1'b0;
      sat = 1'b1;
      host.xfer(1'b1, INT_ENABLES_ADDR, 8'h40);
      int_chk(1'b0);
      sat = 1'b0;
      int_chk(1'b1);
   endtask
   task automatic print_verdict();
      if (n_fail == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #100000;
      n_fail++;
      print_verdict();
   end
   initial begin
      repeat (5) @(posedge clk_sys_i);
      #1;
      rst_b_i = 1'b1;
      t_regs();
      t_calib();
      t_offset();
      t_events();
      print_verdict();
   end
endmodule
